//--- src/adc_device.sv
// Drive command unit: per-axis pulse drive, hold, stop, status and data read.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module adc_device #(
  parameter int unsigned PULSE_DIV = 4,
  parameter int unsigned DECEL_CYC = 8
) (
  // Clock and reset.
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  // Register bus.
  adc_if.dev                              bus,
  // Axis side.
  input  wire logic [adc_pkg::NAXES-1:0]  in_position_input,
  input  wire logic [adc_pkg::NAXES-1:0]  inpos_check_en,
  input  wire logic [adc_pkg::NAXES-1:0]  ext_stop,
  input  wire logic [adc_pkg::NAXES-1:0]  below_start_speed,
  input  wire logic [31:0]                pulse_count [adc_pkg::NAXES],
  input  wire logic [31:0]                sync_buffer_value [adc_pkg::NAXES],
  input  wire logic [adc_pkg::NAXES-1:0]  interp_axes,
  input  wire logic [1:0]                 interp_main,
  input  wire logic [adc_pkg::NAXES-1:0]  interp_done,
  input  wire logic [15:0]                end_status_set,
  input  wire logic                       home_err_set,
  output logic      [adc_pkg::NAXES-1:0]  plus_pulse_out_pos,
  output logic      [adc_pkg::NAXES-1:0]  plus_pulse_out_neg,
  output logic      [adc_pkg::NAXES-1:0]  minus_pulse_out_pos,
  output logic      [adc_pkg::NAXES-1:0]  minus_pulse_out_neg,
  output logic      [31:0]                logical_pos [adc_pkg::NAXES]
);
  import adc_pkg::*;

  typedef enum logic [1:0] {ADC_IDLE, ADC_RUN, ADC_DECEL, ADC_WAITPOS} adc_state_t;

  adc_state_t             st_r [NAXES];
  logic [NAXES-1:0]       hold_r;
  logic [NAXES-1:0]       pend_r;
  logic [NAXES-1:0]       dir_minus_r;
  logic [NAXES-1:0]       cont_r;
  logic [NAXES-1:0]       pulse_r;
  logic [31:0]            left_r [NAXES];
  logic [7:0]             div_r [NAXES];
  logic [7:0]             dec_r [NAXES];
  logic [31:0]            rdbuf_r;
  logic [15:0]            end_st_r;
  logic [15:0]            err_st_r;
  logic                   interp_r;
  logic [15:0]            rdata_r;
  logic                   wr_cmd;
  logic [7:0]             code;
  logic [NAXES-1:0]       axes;
  logic                   is_drive;
  logic                   is_interp;
  logic [NAXES-1:0]       busy;

  assign wr_cmd    = !bus.wr_n && bus.addr == OFF_COMMAND;
  assign code      = bus.wdata[CMD_CODE_LSB +: 8];
  assign axes      = bus.wdata[CMD_AXIS_LSB +: NAXES];
  assign is_drive  = code >= CMD_PLUS_FIXED && code <= CMD_MINUS_CONT;
  // Axis field is ignored for interpolation commands.
  assign is_interp = code >= CMD_INTERP_LO && code <= CMD_INTERP_HI; // [R19]

  // Per-axis drive machine, all designated axes act together.
  always_ff @(posedge clock) begin
    for (int i = 0; i < NAXES; i++) begin
      pulse_r[i] <= 1'b0;
      if (sys_rst) begin
        st_r[i]        <= ADC_IDLE;
        // No hold and no drive survive a reset.
        hold_r[i]      <= 1'b0; // [R24]
        dir_minus_r[i] <= 1'b0;
        cont_r[i]      <= 1'b0;
        left_r[i]      <= 32'h0000_0000;
        div_r[i]       <= 8'h00;
        dec_r[i]       <= 8'h00;
        logical_pos[i] <= 32'h0000_0000;
      end else begin
        if (wr_cmd && is_drive && axes[i] && st_r[i] == ADC_IDLE) begin // [R2] [R3]
          dir_minus_r[i] <= code[0];
          cont_r[i]      <= code[1]; // [R9] [R10]
          left_r[i]      <= pulse_count[i]; // [R7] [R8]
          div_r[i]       <= 8'h00;
          // A held axis keeps the drive pending until the release.
          if (!hold_r[i] && (code[1] || pulse_count[i] != 32'h0000_0000))
            st_r[i] <= ADC_RUN;
        end
        // Hold only marks idle axes; a running drive is untouched.
        if (wr_cmd && code == CMD_HOLD && axes[i] && st_r[i] == ADC_IDLE)
          hold_r[i] <= 1'b1; // [R12] [R13]
        // Release starts every held axis that has a pending drive. Direction and
        // count left over from an earlier drive never restart an axis on their own.
        if (wr_cmd && code == CMD_RELEASE && hold_r[i]) begin // [R14]
          hold_r[i] <= 1'b0;
          if (pend_r[i])
            st_r[i] <= ADC_RUN;
        end
        // One step every PULSE_DIV cycles; the first step leaves with the start.
        if (st_r[i] == ADC_RUN || st_r[i] == ADC_DECEL) begin
          div_r[i] <= (div_r[i] == 8'(PULSE_DIV - 1)) ? 8'h00 : div_r[i] + 8'h01;
          if (div_r[i] == 8'h00) begin
            pulse_r[i] <= 1'b1;
            logical_pos[i] <= dir_minus_r[i] ? logical_pos[i] - 32'h1 : logical_pos[i] + 32'h1;
            if (!cont_r[i]) begin
              left_r[i] <= left_r[i] - 32'h1;
              if (left_r[i] == 32'h1)
                st_r[i] <= inpos_check_en[i] ? ADC_WAITPOS : ADC_IDLE;
            end
          end
          // The ramp is a fixed tail of DECEL_CYC + 1 cycles; the speed curve is not modelled here.
          if (st_r[i] == ADC_DECEL) begin
            dec_r[i] <= dec_r[i] - 8'h01;
            if (dec_r[i] == 8'h00) st_r[i] <= inpos_check_en[i] ? ADC_WAITPOS : ADC_IDLE;
          end
          // The external stop ends continuous drives only; fixed drives run to their count.
          if (st_r[i] == ADC_RUN && ext_stop[i] && cont_r[i])
            st_r[i] <= inpos_check_en[i] ? ADC_WAITPOS : ADC_IDLE; // [R9] [R10]
          // Deceleration stop; immediate when already below start speed.
          if (wr_cmd && code == CMD_DECEL_STOP && axes[i]) begin // [R15] [R18]
            if (below_start_speed[i]) st_r[i] <= inpos_check_en[i] ? ADC_WAITPOS : ADC_IDLE;
            else if (st_r[i] == ADC_RUN) begin
              st_r[i] <= ADC_DECEL;
              dec_r[i] <= 8'(DECEL_CYC);
            end
          end
          // Immediate stop drops the drive at once, even in the middle of the ramp.
          if (wr_cmd && code == CMD_IMM_STOP && axes[i]) // [R17] [R18]
            st_r[i] <= inpos_check_en[i] ? ADC_WAITPOS : ADC_IDLE;
        end
        // Busy clears only once the servo reports in position.
        if (st_r[i] == ADC_WAITPOS && in_position_input[i]) // [R5]
          st_r[i] <= ADC_IDLE;
      end
    end
  end

  // A drive written to a held axis waits here for the release.
  always_ff @(posedge clock) begin
    for (int i = 0; i < NAXES; i++) begin
      if (sys_rst) begin
        pend_r[i] <= 1'b0; // [R24]
      end else if (wr_cmd && code == CMD_RELEASE) begin
        pend_r[i] <= 1'b0;
      end else if (wr_cmd && is_drive && axes[i] && st_r[i] == ADC_IDLE && hold_r[i]) begin
        pend_r[i] <= code[1] || pulse_count[i] != 32'h0000_0000; // [R12]
      end
    end
  end

  // Interpolation busy; a deceleration stop on the main axis ends it.
  // It also ends once every participating axis reports done; an empty set ends at once.
  always_ff @(posedge clock) begin
    if (sys_rst) interp_r <= 1'b0;
    else if (wr_cmd && is_interp) interp_r <= 1'b1; // [R21]
    else if (wr_cmd && code == CMD_DECEL_STOP && axes[interp_main]) interp_r <= 1'b0; // [R16]
    else if ((interp_done & interp_axes) == interp_axes) interp_r <= 1'b0;
  end

  // Pulse outputs are a one-cycle high on the direction's pair.
  always_comb begin
    for (int i = 0; i < NAXES; i++) begin
      busy[i] = st_r[i] != ADC_IDLE || (interp_r && interp_axes[i]); // [R4] [R21]
    end
    plus_pulse_out_pos  = pulse_r & ~dir_minus_r; // [R7] [R9]
    plus_pulse_out_neg  = ~plus_pulse_out_pos;
    minus_pulse_out_pos = pulse_r & dir_minus_r; // [R8] [R10]
    minus_pulse_out_neg = ~minus_pulse_out_pos;
  end

  // Read buffer picks the first designated axis in X, Y, Z, U order.
  always_ff @(posedge clock) begin
    if (sys_rst) rdbuf_r <= 32'h0000_0000;
    else if (wr_cmd && code == CMD_READ_SYNC) begin // [R1]
      for (int i = NAXES - 1; i >= 0; i--)
        if (axes[i]) rdbuf_r <= sync_buffer_value[i]; // [R23]
    end
  end

  // Status bits: hardware set wins over the release clear.
  // Software clears them only through the release command; there is no direct write.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      end_st_r <= 16'h0000;
      err_st_r <= 16'h0000;
    end else begin
      end_st_r <= ((wr_cmd && code == CMD_RELEASE) ? end_st_r & ~END_CLR_MASK : end_st_r)
                  | end_status_set; // [R14]
      err_st_r <= ((wr_cmd && code == CMD_RELEASE) ? err_st_r & ~ERR_CLR_MASK : err_st_r)
                  | (home_err_set ? ERR_CLR_MASK : 16'h0000);
    end
  end

  // Read data stands the cycle after the read strobe.
  // Offsets with no register behind them read as zero.
  always_ff @(posedge clock) begin
    if (sys_rst) rdata_r <= 16'h0000;
    else if (!bus.rd_n) begin
      unique case (bus.addr)
        OFF_MAIN_STATUS: rdata_r <= {7'h00, interp_r, 4'h0, busy};
        OFF_END_STATUS:  rdata_r <= end_st_r;
        OFF_ERR_STATUS:  rdata_r <= err_st_r;
        OFF_DATA_LOW:    rdata_r <= rdbuf_r[15:0];
        OFF_DATA_HIGH:   rdata_r <= rdbuf_r[31:16];
        OFF_CTRL_STATUS: rdata_r <= {12'h000, hold_r};
        default:         rdata_r <= 16'h0000;
      endcase
    end
  end
  assign bus.rdata = rdata_r;
endmodule : adc_device

//--- src/adc_host.sv
// Host end: turns user requests into bus cycles and enforces the command spacing.
`timescale 1ns/1ps
module adc_host (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // User request side.
  input  wire logic         req_valid,
  input  wire logic         req_write,
  input  wire logic [3:0]   req_addr,
  input  wire logic [15:0]  req_wdata,
  output logic              req_ready,
  output logic              rsp_valid,
  output logic [15:0]       rsp_data,
  // Register bus.
  adc_if.host               bus
);
  import adc_pkg::*;

  logic [7:0] gap_r;
  logic       rd_pend_r;
  logic       take;

  // Any access waits out the command processing time after a command write.
  assign req_ready = gap_r == 8'h00; // [R6] [R22]
  assign take      = req_valid && req_ready;

  // Bus strobes and address, driven from flops.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus.addr  <= 4'h0;
      bus.wdata <= 16'h0000;
      bus.wr_n  <= 1'b1;
      bus.rd_n  <= 1'b1;
    end else begin
      bus.wr_n  <= !(take && req_write);
      bus.rd_n  <= !(take && !req_write);
      if (take) begin
        bus.addr  <= req_addr;
        bus.wdata <= req_wdata; // [R19] user supplies zero axis field for interpolation
      end
    end
  end

  // Spacing counter after a command write.
  always_ff @(posedge clock) begin
    if (sys_rst) gap_r <= 8'h00;
    else if (take && req_write && req_addr == OFF_COMMAND) gap_r <= 8'(CMD_CYCLES + 1);
    else if (gap_r != 8'h00) gap_r <= gap_r - 8'h01;
  end

  // Response capture, two cycles after the request is taken.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_pend_r <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rd_pend_r <= !bus.rd_n;
      rsp_valid <= rd_pend_r;
      if (rd_pend_r) rsp_data <= bus.rdata;
    end
  end
endmodule : adc_host

//--- src/adc_if.sv
// Interface joining the host end and the drive unit over the parallel register bus.
`timescale 1ns/1ps
interface adc_if;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_n;
  logic        rd_n;
  logic [15:0] rdata;
  modport host (output addr, output wdata, output wr_n, output rd_n, input rdata);
  modport dev  (input addr, input wdata, input wr_n, input rd_n, output rdata);
endinterface : adc_if

//--- src/adc_pkg.sv
// Package with command codes, register offsets, field positions and timing for the drive unit.
// Functional notes
// R1 - Read 14h returns axis sync buffer value
// R2 - Drive command starts on command write
// R3 - Several designated axes run same command
// R4 - Axis busy bit high while axis drives
// R5 - In-position check delays busy clear
// R6 - Host waits 250 ns between commands
// R7 - 20h emits count plus pulses, counts up
// R8 - 21h emits count minus pulses, counts down
// R9 - 22h runs plus pulses until stop
// R10 - 23h runs minus pulses until stop
// R11 - Host loads speed parameters before drive
// R12 - 24h puts idle axes in start hold
// R13 - Start hold never alters running drive
// R14 - 25h releases hold, clears end/error bits
// R15 - 26h decelerates to stop, immediate below start
// R16 - Decel stop on main axis ends interpolation
// R17 - 27h stops pulses at once
// R18 - Stop on idle axis does nothing
// R19 - Interpolation commands carry zero axis field
// R20 - Host selects axes before interpolation
// R21 - Interpolation busy and axis busy during interpolation
// R22 - Host waits 250 ns before reading data
// R23 - Multi-axis read picks X, Y, Z, U
// R24 - Hold persists until release or reset
package adc_pkg;
  localparam int unsigned NAXES       = 4;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned CMD_TIME_NS = 250;
  localparam int unsigned CMD_CYCLES  = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
  // Command register fields.
  localparam int unsigned CMD_CODE_LSB = 0;
  localparam int unsigned CMD_AXIS_LSB = 8;
  // Command codes.
  localparam logic [7:0] CMD_READ_SYNC  = 8'h14;
  localparam logic [7:0] CMD_PLUS_FIXED = 8'h20;
  localparam logic [7:0] CMD_MINUS_FIXED= 8'h21;
  localparam logic [7:0] CMD_PLUS_CONT  = 8'h22;
  localparam logic [7:0] CMD_MINUS_CONT = 8'h23;
  localparam logic [7:0] CMD_HOLD       = 8'h24;
  localparam logic [7:0] CMD_RELEASE    = 8'h25;
  localparam logic [7:0] CMD_DECEL_STOP = 8'h26;
  localparam logic [7:0] CMD_IMM_STOP   = 8'h27;
  localparam logic [7:0] CMD_INTERP_LO  = 8'h30;
  localparam logic [7:0] CMD_INTERP_HI  = 8'h35;
  // Software port offsets.
  localparam logic [3:0] OFF_COMMAND     = 4'h0;
  localparam logic [3:0] OFF_MAIN_STATUS = 4'h1;
  localparam logic [3:0] OFF_END_STATUS  = 4'h2;
  localparam logic [3:0] OFF_ERR_STATUS  = 4'h3;
  localparam logic [3:0] OFF_DATA_LOW    = 4'h4;
  localparam logic [3:0] OFF_DATA_HIGH   = 4'h5;
  localparam logic [3:0] OFF_CTRL_STATUS = 4'h6;
  // Status field positions.
  localparam int unsigned ST_INTERP_BIT = 8;
  localparam int unsigned ST_HOME_ERR   = 7;
  localparam int unsigned ST_END_LSB    = 8;
  localparam logic [15:0] END_CLR_MASK  = 16'hFF00;
  localparam logic [15:0] ERR_CLR_MASK  = 16'h0080;
endpackage : adc_pkg

//--- tb/adc_checker.sv
// Checker for the register bus between the host end and the drive unit.
`timescale 1ns/1ps
module adc_checker (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        sys_rst,
  // Register bus.
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_n,
  input wire logic        rd_n,
  input wire logic [15:0] rdata
);
  import adc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] gap_r;
  wire        cmd_wr = !wr_n && addr == OFF_COMMAND;
  // Cycles since the last command write; saturates so old writes stop mattering.
  always_ff @(posedge clock) begin
    if (sys_rst)
      gap_r <= 8'hFF;
    else if (cmd_wr)
      gap_r <= 8'h01;
    else if (gap_r != 8'hFF)
      gap_r <= gap_r + 8'h01;
  end
  a_no_dual_strobe: assert property (!(!wr_n && !rd_n))
    else $error("both strobes low");
  // Strobes may follow each other back to back, except right after a command write.
  a_cmd_then_quiet: assert property (cmd_wr |=> wr_n && rd_n)
    else $error("access right after a command write");
  a_status_layout: assert property ((!rd_n && addr == OFF_MAIN_STATUS) |=>
    rdata[15:9] == 7'h00 && rdata[7:4] == 4'h0)
    else $error("main status reserved bits set");
  a_cmd_spacing: assert property (cmd_wr |-> gap_r >= CMD_CYCLES)
    else $error("command written too soon");
  a_data_read_wait: assert property ((!rd_n && addr == OFF_DATA_LOW) |-> gap_r >= CMD_CYCLES)
    else $error("data read too soon");
  a_any_strobe_wait: assert property ((!wr_n || !rd_n) |-> gap_r >= CMD_CYCLES)
    else $error("access inside command time");
  a_rdata_stands: assert property ($past(rd_n) |-> $stable(rdata))
    else $error("read data moved without a read");
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> wr_n && rd_n)
    else $error("strobe during reset");
  c_cmd_write: cover property (cmd_wr);
  c_high_read: cover property (!rd_n && addr == OFF_DATA_HIGH);
  c_b2b_read: cover property (!rd_n ##1 !rd_n);
endmodule : adc_checker

//--- tb/test_axis_drive_command_unit.sv
// Bench joining host end and drive unit, driving user requests and axis inputs.
`timescale 1ns/1ps
module test_axis_drive_command_unit;
  import adc_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, err_set = 1'b0;
  logic [3:0]  req_addr = 4'h0, in_pos = 4'h0, chk_en = 4'h0, ext_stop = 4'h0, ax;
  logic [3:0]  slow = 4'h0, iax = 4'h0, idone = 4'h0, plus_p, minus_p;
  logic [15:0] req_wdata = 16'h0, end_set = 16'h0, rsp_data, q, d;
  logic [31:0] pcnt [NAXES] = '{default: 32'h0};
  logic [31:0] sbuf [NAXES] = '{default: 32'h0};
  logic [31:0] logical_pos [NAXES];
  logic [1:0]  imain = 2'h0;
  int          mpos [NAXES], base [NAXES], fails = 0, n_tests = 0;
  adc_if i_adc_if ();
  adc_host i_adc_host (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(i_adc_if));
  adc_device #(.PULSE_DIV(4), .DECEL_CYC(8)) i_adc_device (.clock(clock), .sys_rst(sys_rst),
    .bus(i_adc_if), .in_position_input(in_pos), .inpos_check_en(chk_en), .ext_stop(ext_stop),
    .below_start_speed(slow), .pulse_count(pcnt), .sync_buffer_value(sbuf),
    .interp_axes(iax), .interp_main(imain), .interp_done(idone), .end_status_set(end_set),
    .home_err_set(err_set), .plus_pulse_out_pos(plus_p), .plus_pulse_out_neg(),
    .minus_pulse_out_pos(minus_p), .minus_pulse_out_neg(), .logical_pos(logical_pos));
  adc_checker i_adc_checker (.clock(clock), .sys_rst(sys_rst), .addr(i_adc_if.addr),
    .wdata(i_adc_if.wdata), .wr_n(i_adc_if.wr_n), .rd_n(i_adc_if.rd_n),
    .rdata(i_adc_if.rdata));
  // Free-running clock.
  always #5 clock = ~clock;
  // Position seen from the pulse wires, so the counter is judged against real pulses.
  always @(posedge clock)
    for (int a = 0; a < NAXES; a++)
      mpos[a] = sys_rst ? 0 : mpos[a] + plus_p[a] - minus_p[a];
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic hang;
    fails++;
    print_verdict();
  endtask : hang
  // One request; the host refuses while a command is still being processed.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] v);
    int k;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= v;
    k = 0;
    do begin @(negedge clock); k++; end while (req_ready !== 1'b1 && k < 99);
    if (req_ready !== 1'b1) hang();
    @(posedge clock);
    req_valid <= 1'b0;
    k = 0;
    if (!w) do begin @(negedge clock); k++; end while (rsp_valid !== 1'b1 && k < 9);
    if (!w && rsp_valid !== 1'b1) hang();
    q = rsp_data;
  endtask : xfer
  task automatic cmd(input logic [7:0] c, input logic [3:0] m);
    xfer(1'b1, OFF_COMMAND, {4'h0, m, c});
  endtask : cmd
  task automatic rdm(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    xfer(1'b0, a, 16'h0);
    check(q & m, e);
  endtask : rdm
  task automatic wait_idle(input logic [15:0] m);
    int k;
    k = 0;
    do begin xfer(1'b0, OFF_MAIN_STATUS, 16'h0); k++; end while ((q & m) !== 16'h0 && k < 200);
    if ((q & m) !== 16'h0) hang();
  endtask : wait_idle
  // Lowest set bit wins: X before Y before Z before U.
  function automatic int first_ax(input logic [3:0] m);
    first_ax = 0;
    for (int i = 3; i >= 0; i--) if (m[i]) first_ax = i;
  endfunction : first_ax
  initial begin
    void'($urandom(32'h71B5));
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdm(OFF_MAIN_STATUS, 16'hFFFF, 16'h0);
    rdm(OFF_CTRL_STATUS, 16'h000F, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      for (int a = 0; a < NAXES; a++) sbuf[a] <= $urandom;
      ax = (i == 0) ? 4'hF : 4'($urandom_range(1, 15));
      cmd(CMD_READ_SYNC, ax);
      xfer(1'b0, OFF_DATA_LOW, 16'h0);
      d = q;
      xfer(1'b0, OFF_DATA_HIGH, 16'h0);
      check({q, d}, sbuf[first_ax(ax)]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      for (int a = 0; a < NAXES; a++) pcnt[a] <= 32'($urandom_range(12, 20));
      ax = (i == 0) ? 4'hF : 4'($urandom_range(1, 15));
      base = mpos;
      cmd(i[0] ? CMD_MINUS_FIXED : CMD_PLUS_FIXED, ax);
      rdm(OFF_MAIN_STATUS, 16'h000F, {12'h0, ax});
      wait_idle(16'h000F);
      for (int a = 0; a < NAXES; a++) begin
        check(mpos[a] - base[a], ax[a] ? (i[0] ? -pcnt[a] : pcnt[a]) : 32'h0);
        check(logical_pos[a], mpos[a]);
      end
    end
    // Continuous drives ended by each stop path; hold written mid-drive must not stop them.
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      slow <= 4'($urandom);
      ax = 4'($urandom_range(1, 15));
      cmd(i[0] ? CMD_MINUS_CONT : CMD_PLUS_CONT, ax);
      cmd(CMD_HOLD, ax);
      rdm(OFF_MAIN_STATUS, 16'h000F, {12'h0, ax});
      if (i == 2) @(posedge clock);
      if (i == 2) ext_stop <= ax;
      else cmd(i[0] ? CMD_IMM_STOP : CMD_DECEL_STOP, ax);
      // Snapshot the count once any step launched beside the stop has been seen.
      if (i == 1) begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        base = mpos;
      end
      wait_idle(16'h000F);
      if (i == 1)
        for (int a = 0; a < NAXES; a++) check(mpos[a] - base[a], 32'h0);
      @(posedge clock);
      ext_stop <= 4'h0;
      for (int a = 0; a < NAXES; a++) check(logical_pos[a], mpos[a]);
      cmd(CMD_RELEASE, 4'hF);
    end
    base = mpos;
    cmd(CMD_IMM_STOP, 4'hF);
    cmd(CMD_DECEL_STOP, 4'hF);
    rdm(OFF_MAIN_STATUS, 16'h000F, 16'h0);
    check(mpos[1] - base[1], 32'h0);
    @(posedge clock);
    for (int a = 0; a < NAXES; a++) pcnt[a] <= 32'h10;
    end_set <= 16'hFF00;
    err_set <= 1'b1;
    @(posedge clock);
    end_set <= 16'h0;
    err_set <= 1'b0;
    cmd(CMD_HOLD, 4'h5);
    cmd(CMD_PLUS_FIXED, 4'h5);
    rdm(OFF_MAIN_STATUS, 16'h000F, 16'h0);
    rdm(OFF_CTRL_STATUS, 16'h000F, 16'h5);
    rdm(OFF_END_STATUS, END_CLR_MASK, END_CLR_MASK);
    rdm(OFF_ERR_STATUS, ERR_CLR_MASK, ERR_CLR_MASK);
    cmd(CMD_RELEASE, 4'hF);
    rdm(OFF_MAIN_STATUS, 16'h000F, 16'h5);
    rdm(OFF_END_STATUS, END_CLR_MASK, 16'h0);
    rdm(OFF_ERR_STATUS, ERR_CLR_MASK, 16'h0);
    wait_idle(16'h000F);
    @(posedge clock);
    chk_en <= 4'h1;
    pcnt[0] <= 32'h4;
    cmd(CMD_PLUS_FIXED, 4'h1);
    rdm(OFF_MAIN_STATUS, 16'h0001, 16'h1);
    @(posedge clock);
    in_pos <= 4'h1;
    wait_idle(16'h0001);
    @(posedge clock);
    iax <= 4'h3;
    cmd(CMD_INTERP_LO, 4'h0);
    rdm(OFF_MAIN_STATUS, 16'h01FF, 16'h0103);
    @(posedge clock);
    idone <= 4'hF;
    wait_idle(16'h0103);
    @(posedge clock);
    idone <= 4'h0;
    imain <= 2'h1;
    cmd(CMD_INTERP_HI, 4'h0);
    cmd(CMD_DECEL_STOP, 4'h1);
    rdm(OFF_MAIN_STATUS, 16'h0100, 16'h0100);
    cmd(CMD_DECEL_STOP, 4'h2);
    wait_idle(16'h0103);
    // A reset while every axis is held must drop the hold and leave every axis idle.
    cmd(CMD_HOLD, 4'hF);
    rdm(OFF_CTRL_STATUS, 16'h000F, 16'h000F);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdm(OFF_CTRL_STATUS, 16'h000F, 16'h0);
    rdm(OFF_MAIN_STATUS, 16'hFFFF, 16'h0);
    print_verdict();
  end
endmodule : test_axis_drive_command_unit
